// file: hw/adc_ctrl_pkg.sv
// Shared constants and types for the converter control block.
package adc_ctrl_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int          RESULT_W        = 16;
  localparam int          HALF_W          = 8;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          CONV_TIME_NS    = 1130;
  localparam int          ACQ_TIME_NS     = 200;
  localparam int          CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int          ACQ_CYCLES      = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W           = 8;
  localparam int          FIFO_DEPTH      = 8;
  localparam logic [7:0]  FOLD_FILL       = 8'hff;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [15:0] LFSR_SEED       = 16'h1d2b;
  localparam logic [15:0] LFSR_TAPS       = 16'hb400;

  // ****************************************************************
  // Converter states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQUIRE,
    ST_CONVERT
  } conv_state_e;

endpackage

// file: hw/result_fifo.sv
// Small synchronous FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [WIDTH-1:0] dout;
    logic          dvalid;
  } fifo_s;

  logic [WIDTH-1:0] mem_r [DEPTH];
  fifo_s            st_r;
  fifo_s            st_nxt;
  logic             push;
  logic             pop;
  logic             mem_empty;
  logic             deq;

  // The count holds every word, the one in the output register included.
  assign mem_empty = (st_r.count == (AW+1)'(st_r.dvalid));
  assign in_ready  = (st_r.count != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign deq       = out_ready && st_r.dvalid;
  assign pop       = !mem_empty && (!st_r.dvalid || out_ready);
  assign out_valid = st_r.dvalid;
  assign out_data  = st_r.dout;

  always_comb begin
    st_nxt = st_r;
    if (deq) begin
      st_nxt.dvalid = 1'b0;
    end
    if (pop) begin
      st_nxt.dout   = mem_r[st_r.rd_ptr];
      st_nxt.dvalid = 1'b1;
      st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH-1)) ? '0 : st_r.rd_ptr + 1'b1;
    end
    if (push) begin
      st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH-1)) ? '0 : st_r.wr_ptr + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(deq);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[st_r.wr_ptr] <= in_data;
    end
  end

endmodule
`default_nettype wire

// file: hw/adc_ctrl.sv
// Conversion control and parallel result readout of a sampling converter.
//
// How it works
// - Busy is high for the whole conversion and low at every other time.
// - A falling trigger with chip select low and room in the result FIFO ends acquisition and freezes the sampled input XORed with the LFSR word for conversion.
// - A falling chip select in the idle state starts a new acquisition period.
// - With fold select at zero the full result appears on bus lines fifteen to zero.
// - With fold select at one result bits seven to zero go on the upper lines, lower lines all ones.
// - The read strobe acts as output enable and puts the previous result on the bus.
// - All four chip select and read strobe styles work, both low giving automatic output.
// - Busy rises right after the trigger falls and drops when the conversion ends.
// - Sampling starts at busy falling with chip select low, else at chip select falling.
// - The bus is driven from one cycle after chip select and read strobe are both sampled low until one cycle after either rises.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl #(
  parameter int CONV_CNT = adc_ctrl_pkg::CONV_CYCLES,
  parameter int DEPTH    = adc_ctrl_pkg::FIFO_DEPTH
) (
  input  wire logic                            ref_clk,
  input  wire logic                            arst_n,
  input  wire logic                            conversion_trigger_n,
  input  wire logic                            cs_n,
  input  wire logic                            rd_n,
  input  wire logic                            fold_sel,
  input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] analog_code,
  output logic                                 busy,
  output logic                                 sampling,
  output logic [adc_ctrl_pkg::RESULT_W-1:0]    bus_out,
  output logic [adc_ctrl_pkg::RESULT_W-1:0]    bus_oe,
  input  wire logic                            result_ready,
  output logic                                 result_valid,
  output logic [adc_ctrl_pkg::RESULT_W-1:0]    result_data
);

  import adc_ctrl_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    conv_state_e         state;
    logic [CNT_W-1:0]    cnt;
    logic                trig_d;
    logic                cs_d;
    logic [RESULT_W-1:0] held;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] lfsr;
    logic [RESULT_W-1:0] bus_data;
    logic                bus_en;
  } ctrl_s;

  ctrl_s               st_r;
  ctrl_s               st_nxt;
  logic                trig_fall;
  logic                cs_fall;
  logic                fifo_in_ready;
  logic [RESULT_W-1:0] bus_view;
  logic                conv_last;

  assign trig_fall = st_r.trig_d && !conversion_trigger_n;
  assign cs_fall   = st_r.cs_d && !cs_n;
  // The result is pushed in the last conversion cycle, so the room check at the next trigger is exact.
  assign conv_last = (st_r.state == ST_CONVERT) && (st_r.cnt == CNT_W'(CONV_CNT - 1));

  // ****************************************************************
  // Result view on the bus
  // ****************************************************************
  always_comb begin
    if (fold_sel) begin
      bus_view = {st_r.result[HALF_W-1:0], FOLD_FILL};
    end else begin
      bus_view = st_r.result;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always_comb begin
    st_nxt        = st_r;
    st_nxt.trig_d = conversion_trigger_n;
    st_nxt.cs_d   = cs_n;
    st_nxt.lfsr   = st_r.lfsr[0] ? ((st_r.lfsr >> 1) ^ LFSR_TAPS) : (st_r.lfsr >> 1);
    case (st_r.state)
      ST_IDLE: begin
        if (cs_fall) begin
          st_nxt.state = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (trig_fall && !cs_n && fifo_in_ready) begin
          st_nxt.held  = analog_code ^ st_r.lfsr;
          st_nxt.cnt   = '0;
          st_nxt.state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        if (conv_last) begin
          st_nxt.result = st_r.held;
          if (!cs_n) begin
            st_nxt.state = ST_ACQUIRE;
          end else begin
            st_nxt.state = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
    st_nxt.bus_en   = !cs_n && !rd_n;
    st_nxt.bus_data = bus_view;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r        <= '0;
      st_r.state  <= ST_IDLE;
      st_r.trig_d <= 1'b1;
      st_r.cs_d   <= 1'b1;
      st_r.result <= RESULT_RESET;
      st_r.lfsr   <= LFSR_SEED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign busy     = (st_r.state == ST_CONVERT);
  assign sampling = (st_r.state == ST_ACQUIRE);
  assign bus_out  = st_r.bus_data;
  assign bus_oe   = {RESULT_W{st_r.bus_en}};

  // ****************************************************************
  // Result stream
  // ****************************************************************
  result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_data   (st_r.held),
    .in_valid  (conv_last),
    .in_ready  (fifo_in_ready),
    .out_data  (result_data),
    .out_valid (result_valid),
    .out_ready (result_ready)
  );

endmodule
`default_nettype wire

// file: sim/adc_ctrl_sva.sv
// Assertion checker for the converter control ports.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva #(
  parameter int CONV_CNT = 11
) (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        conversion_trigger_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        fold_sel,
  input wire logic        busy,
  input wire logic        sampling,
  input wire logic [15:0] bus_out,
  input wire logic [15:0] bus_oe,
  input wire logic        result_valid
);
  int busy_cnt_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) busy_cnt_r <= 0;
    else busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
  end
  a_busy_rise: assert property ($fell(conversion_trigger_n) && sampling && !cs_n
    && !busy && !result_valid |=> busy) else $error("busy did not rise");
  a_busy_cause: assert property ($rose(busy) |-> $past(sampling) && !$past(cs_n)
    && !$past(conversion_trigger_n)) else $error("busy rose without trigger");
  a_busy_length: assert property ($fell(busy) |-> busy_cnt_r == CONV_CNT)
    else $error("conversion length wrong");
  a_oe_on: assert property (!cs_n && !rd_n |=> bus_oe == 16'hffff)
    else $error("bus not driven");
  a_oe_off: assert property (cs_n || rd_n |=> bus_oe == 16'h0000)
    else $error("bus driven while deselected");
  a_fold_fill: assert property ($past(fold_sel) && bus_oe[0] |-> bus_out[7:0] == 8'hff)
    else $error("fold fill wrong");
  a_acq_start: assert property ($fell(cs_n) && !busy |=> sampling)
    else $error("no acquisition on select");
  a_acq_after: assert property ($fell(busy) && !cs_n && !$past(cs_n) |-> sampling)
    else $error("no acquisition after busy");
  c_conv: cover property ($fell(busy));
  c_read: cover property ($rose(bus_oe[0]));
  c_fold: cover property (fold_sel && bus_oe[0]);
  c_select: cover property ($fell(cs_n) && !busy && !sampling);
endmodule
bind adc_ctrl adc_ctrl_sva #(.CONV_CNT(CONV_CNT)) u_adc_ctrl_sva (
  .ref_clk              (ref_clk),
  .arst_n               (arst_n),
  .conversion_trigger_n (conversion_trigger_n),
  .cs_n                 (cs_n),
  .rd_n                 (rd_n),
  .fold_sel             (fold_sel),
  .busy                 (busy),
  .sampling             (sampling),
  .bus_out              (bus_out),
  .bus_oe               (bus_oe),
  .result_valid         (result_valid)
);
`default_nettype wire

// file: sim/host_model.sv
// Host model that drives the converter control pins.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic   ref_clk,
  output logic        conversion_trigger_n,
  output logic        cs_n,
  output logic        rd_n,
  output logic        fold_sel,
  output logic        result_ready,
  output logic [15:0] analog_code
);
  // Starts with every strobe released and the sink not ready.
  initial begin
    conversion_trigger_n = 1'b1;
    {cs_n, rd_n, fold_sel, result_ready} = 4'hc;
    analog_code = 16'h0123;
  end
  // Sets chip select, read strobe, fold select and sink ready together.
  task automatic pins(input logic [3:0] v);
    @(posedge ref_clk);
    #1;
    {cs_n, rd_n, fold_sel, result_ready} = v;
  endtask
  // Holds the trigger low for one full cycle, longer than the minimum.
  task automatic convert();
    @(posedge ref_clk);
    #1;
    analog_code = analog_code + 16'h1111;
    conversion_trigger_n = 1'b0;
    @(posedge ref_clk);
    #1;
    conversion_trigger_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/test_adc_ctrl.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module test_adc_ctrl;
  import adc_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n  = 1'b0;
  wire logic conversion_trigger_n, cs_n, rd_n, fold_sel, result_ready;
  wire logic [15:0] analog_code;
  logic busy, sampling, result_valid;
  logic [15:0] bus_out, bus_oe, result_data;
  int num_errors = 0;
  int tests_run  = 0;
  adc_ctrl #(.CONV_CNT(4)) u_adc_ctrl (
    .ref_clk              (ref_clk),
    .arst_n               (arst_n),
    .conversion_trigger_n (conversion_trigger_n),
    .cs_n                 (cs_n),
    .rd_n                 (rd_n),
    .fold_sel             (fold_sel),
    .analog_code          (analog_code),
    .busy                 (busy),
    .sampling             (sampling),
    .bus_out              (bus_out),
    .bus_oe               (bus_oe),
    .result_ready         (result_ready),
    .result_valid         (result_valid),
    .result_data          (result_data)
  );
  host_model u_host_model (
    .ref_clk              (ref_clk),
    .conversion_trigger_n (conversion_trigger_n),
    .cs_n                 (cs_n),
    .rd_n                 (rd_n),
    .fold_sel             (fold_sel),
    .result_ready         (result_ready),
    .analog_code          (analog_code)
  );
  always #50 ref_clk = ~ref_clk;
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 40) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    check16(16'(busy), 16'(lvl), "busy wait");
  endtask
  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic t_toggle();
    u_host_model.pins(4'h4);
    u_host_model.convert();
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (3) step();
    check16(bus_oe, 16'h0000, "bus driven");
    u_host_model.pins(4'h0);
    step();
    check16(bus_oe, 16'hffff, "bus idle");
    check16(bus_out, result_data, "word view");
    u_host_model.pins(4'h2);
    step();
    check16(bus_out, {result_data[7:0], FOLD_FILL}, "fold view");
    u_host_model.pins(4'hd);
    u_host_model.pins(4'hc);
    step();
    check16(bus_oe, 16'h0000, "bus held");
  endtask
  task automatic t_auto();
    u_host_model.pins(4'h0);
    u_host_model.convert();
    wait_busy(1'b1);
    wait_busy(1'b0);
    check16(16'(sampling), 16'h0001, "no sampling");
    u_host_model.convert();
    wait_busy(1'b1);
    wait_busy(1'b0);
    check16(bus_oe, 16'hffff, "auto read");
    u_host_model.pins(4'hd);
    repeat (4) step();
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    u_host_model.pins(4'h4);
    for (int i = 0; i < 9; i++) begin
      u_host_model.convert();
      if (i < 8) begin
        wait_busy(1'b1);
        wait_busy(1'b0);
      end
    end
    repeat (3) step();
    check16(16'(busy), 16'h0000, "full not refused");
    u_host_model.pins(4'hd);
    repeat (20) begin
      if (result_valid === 1'b1) n++;
      step();
    end
    check16(16'(n), 16'h0008, "fifo count");
  endtask
  task automatic t_styles();
    u_host_model.pins(4'h5);
    u_host_model.convert();
    u_host_model.pins(4'hd);
    wait_busy(1'b0);
    step();
    check16(16'(sampling), 16'h0000, "sampling while deselected");
    u_host_model.convert();
    repeat (2) step();
    check16(16'(busy), 16'h0000, "deselected trigger taken");
    u_host_model.pins(4'h9);
    step();
    check16(bus_oe, 16'h0000, "read while deselected");
    u_host_model.pins(4'h1);
    step();
    check16(16'(sampling), 16'h0001, "no acquisition on select");
    check16(bus_oe, 16'hffff, "select with read low");
    u_host_model.pins(4'h5);
    step();
    check16(bus_oe, 16'h0000, "bus driven with read high");
    u_host_model.pins(4'h1);
    step();
    check16(bus_oe, 16'hffff, "read strobe low");
    u_host_model.pins(4'hd);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    t_toggle();
    t_auto();
    t_fill();
    t_styles();
    end_of_test();
  end
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
